// [shared/shift4_consts.svh]
// Constants for the four-stage shift register and its word buffer
`ifndef SHIFT4_CONSTS_SVH
`define SHIFT4_CONSTS_SVH

`define SR_STAGES 4
`define SR_CLEAR_WORD 4'h0
`define SR_RESET_WORD 4'h0
`define SR_RESET_INV 1'h1
`define SR_PIN_BITS 9
`define SR_PIN_RESET 9'h000
`define SR_CLK_POS 8
`define SR_CLR_POS 7
`define SR_LOAD_POS 6
`define SR_SHIFT_POS 5
`define SR_SER_POS 4
`define SR_CLK_NS 20
`define SR_CLK_MHZ 50
`define SR_SYNC_CYCLES 2

`endif

// [shared/shift4_pkg.sv]
// Types shared by the shift register and its word buffer
package shift4_pkg;
   typedef logic [3:0] stage_word_t;
   typedef enum logic [1:0] {
      MODE_HOLD,
      MODE_SHIFT,
      MODE_LOAD
   } mode_t;
endpackage

// [shared/word_stream_if.sv]
// Valid/ready word stream from the shift register into its buffer
`timescale 1ns/1ps
interface word_stream_if;
   logic valid;
   logic ready;
   shift4_pkg::stage_word_t data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// [src/pair_buffer.sv]
// Two-entry skid buffer between the register and the word receiver
`timescale 1ns/1ps
`include "shift4_consts.svh"
module pair_buffer (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Filling side
   word_stream_if.snk fill,
   // Draining side
   output logic out_valid,
   output shift4_pkg::stage_word_t out_data,
   input wire logic out_ready
);
   shift4_pkg::stage_word_t head_q, head_d, skid_q, skid_d;
   logic head_v_q, head_v_d, skid_v_q, skid_v_d, room_q, room_d;
   logic push, pop;

   // Ready is registered, so a word is only offered room the skid slot really has
   assign push = fill.valid & room_q;
   assign pop = head_v_q & out_ready;
   assign fill.ready = room_q;
   assign out_valid = head_v_q;
   assign out_data = head_q;

   // Head drains first; the skid slot catches a word while the receiver stalls
   always_comb begin
      head_d = head_q;
      head_v_d = head_v_q;
      skid_d = skid_q;
      skid_v_d = skid_v_q;
      if (pop) begin
         head_v_d = 1'b0;
      end
      if (skid_v_d && !head_v_d) begin
         head_d = skid_d;
         head_v_d = 1'b1;
         skid_v_d = 1'b0;
      end
      if (push) begin
         if (!head_v_d) begin
            head_d = fill.data;
            head_v_d = 1'b1;
         end else begin
            skid_d = fill.data;
            skid_v_d = 1'b1;
         end
      end
      room_d = ~skid_v_d;
   end

   // Buffer state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         head_q <= `SR_RESET_WORD;
         skid_q <= `SR_RESET_WORD;
         head_v_q <= 1'b0;
         skid_v_q <= 1'b0;
         room_q <= 1'b1;
      end else begin
         head_q <= head_d;
         skid_q <= skid_d;
         head_v_q <= head_v_d;
         skid_v_q <= skid_v_d;
         room_q <= room_d;
      end
   end

   // A stalled receiver never loses the word it is being offered
   a_head_holds: assert property (@(posedge mclk) disable iff (!rst_n)
      head_v_q && !out_ready |=> head_v_q && $stable(head_q))
      else $error("buffered word changed while stalled");
endmodule

// [src/shift4_reg.sv]
// Four-stage shift register with load, shift, hold and clear, sampled from pins
`timescale 1ns/1ps
`include "shift4_consts.svh"
module shift4_reg (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Pins from the controlling logic
   input wire logic clk_pin,
   input wire logic clear_n_pin,
   input wire logic load_pin,
   input wire logic shift_pin,
   input wire logic ser_pin,
   input wire logic [3:0] par_pin,
   // Stage outputs
   output shift4_pkg::stage_word_t par_out,
   output logic ser_out,
   output logic ser_out_n,
   // Word stream of the stage value after each falling edge of the clock pin
   output logic word_valid,
   output shift4_pkg::stage_word_t word_data,
   input wire logic word_ready,
   output logic word_room
);
   // Reset release
   logic rst_meta_q, rst_n_q;

   // Pin synchroniser and edge history
   logic [`SR_PIN_BITS-1:0] pin_meta_q, pin_sync_q, pins;
   logic clk_prev_q, clk_prev_d;
   logic clk_s, clear_n_s, load_s, shift_s, ser_s;
   shift4_pkg::stage_word_t par_s;
   logic fall;

   // Stage state
   shift4_pkg::mode_t mode;
   shift4_pkg::stage_word_t stage_q, stage_d;
   logic inv_q, inv_d;

   // Stream source state
   logic push_q, push_d;
   logic room_q, room_d;
   logic out_valid_b;
   shift4_pkg::stage_word_t out_data_b;
   logic valid_q, valid_d;
   shift4_pkg::stage_word_t data_q, data_d;

   word_stream_if words ();

   // Reset is asserted at once but released only after two clean edges
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // All pins are asynchronous to mclk; sample them together so they stay aligned
   assign pins = {clk_pin, clear_n_pin, load_pin, shift_pin, ser_pin, par_pin};

   // Two flip-flops per pin; only the second stage is read by logic
   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin_meta_q <= `SR_PIN_RESET;
         pin_sync_q <= `SR_PIN_RESET;
      end else begin
         pin_meta_q <= pins;
         pin_sync_q <= pin_meta_q;
      end
   end

   // Named views of the synchronised pins
   assign clk_s = pin_sync_q[`SR_CLK_POS];
   assign clear_n_s = pin_sync_q[`SR_CLR_POS];
   assign load_s = pin_sync_q[`SR_LOAD_POS];
   assign shift_s = pin_sync_q[`SR_SHIFT_POS];
   assign ser_s = pin_sync_q[`SR_SER_POS];
   assign par_s = pin_sync_q[3:0];

   // Falling edge of the clock pin; the rising edge does nothing
   assign fall = clk_prev_q & ~clk_s;
   assign clk_prev_d = clk_s;

   // Mode from the two controls; shift dominates load
   always_comb begin
      unique case ({load_s, shift_s})
         2'b00: mode = shift4_pkg::MODE_HOLD;
         2'b01: mode = shift4_pkg::MODE_SHIFT;
         2'b11: mode = shift4_pkg::MODE_SHIFT;
         2'b10: mode = shift4_pkg::MODE_LOAD;
      endcase
   end

   // Next stage word; the edge is taken even during clear, so the new value
   // shows for one mclk cycle before clear pulls the stages back to zero
   always_comb begin
      stage_d = stage_q;
      if (fall) begin
         unique case (mode)
            shift4_pkg::MODE_HOLD: stage_d = stage_q;
            shift4_pkg::MODE_SHIFT: stage_d = {stage_q[2:0], ser_s};
            shift4_pkg::MODE_LOAD: stage_d = par_s;
         endcase
      end else if (!clear_n_s) begin
         stage_d = `SR_CLEAR_WORD;
      end
      inv_d = ~stage_d[3];
   end

   // Stage registers; a free-running pin clock is fine since hold keeps data
   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         stage_q <= `SR_RESET_WORD;
         inv_q <= `SR_RESET_INV;
         clk_prev_q <= 1'b0;
      end else begin
         stage_q <= stage_d;
         inv_q <= inv_d;
         clk_prev_q <= clk_prev_d;
      end
   end

   // Outputs are the stage flops themselves, so there is no added delay
   assign par_out = stage_q;
   assign ser_out = stage_q[3];
   assign ser_out_n = inv_q;

   // Every falling edge offers the new stage word to the buffer
   assign push_d = fall;
   assign words.valid = push_q;
   assign words.data = stage_q;

   // Output stage of the stream, registered so every output comes from a flop
   always_comb begin
      valid_d = valid_q;
      data_d = data_q;
      if (!valid_q || word_ready) begin
         valid_d = out_valid_b;
         data_d = out_data_b;
      end
      room_d = words.ready;
   end

   // Stream registers
   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         push_q <= 1'b0;
         room_q <= 1'b0;
         valid_q <= 1'b0;
         data_q <= `SR_RESET_WORD;
      end else begin
         push_q <= push_d;
         room_q <= room_d;
         valid_q <= valid_d;
         data_q <= data_d;
      end
   end

   // The pin clock cannot be stalled, so room is reported for the caller to honour
   assign word_valid = valid_q;
   assign word_data = data_q;
   assign word_room = room_q;

   // Buffer drains into the output stage whenever that stage is free
   pair_buffer u_buf (
      .mclk(mclk),
      .rst_n(rst_n_q),
      .fill(words.snk),
      .out_valid(out_valid_b),
      .out_data(out_data_b),
      .out_ready(!valid_q || word_ready)
   );

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n_q);

   // Hold mode keeps the word across an edge
   a_hold_keeps: assert property (
      fall && !load_s && !shift_s |=> stage_q == $past(stage_q))
      else $error("hold edge changed the stages");

   // Serial bit enters stage one with load ignored
   a_shift_entry: assert property (
      fall && shift_s |=> stage_q[0] == $past(ser_s))
      else $error("serial bit not taken on shift");

   // Each stage passes its bit on during a shift
   a_shift_chain: assert property (
      fall && shift_s |=> stage_q[3:1] == $past(stage_q[2:0]))
      else $error("shift chain broken");

   // Parallel load copies all four inputs
   a_load_copy: assert property (
      fall && load_s && !shift_s |=> par_out == $past(par_s))
      else $error("parallel load missed");

   // No edge and no clear means no change
   a_no_edge: assert property (
      !fall && clear_n_s |=> $stable(stage_q))
      else $error("stages moved without a falling edge");

   // Clear without an edge zeroes the stages
   a_clear_zero: assert property (
      !fall && !clear_n_s |=> stage_q == 4'h0)
      else $error("clear did not zero the stages");

   // Edge during clear shows briefly, then clear wins again
   a_edge_spike: assert property (
      fall && !clear_n_s && load_s && !shift_s ##1 (!fall && !clear_n_s)
      |-> $past(par_s) == stage_q ##1 stage_q == 4'h0)
      else $error("edge during clear not handled");

   // Inverted fourth stage
   a_inv_out: assert property (
      ser_out_n != ser_out)
      else $error("inverted output wrong");

   // Serial output is the last parallel bit
   a_ser_tap: assert property (
      ser_out == par_out[3] && par_out == stage_q)
      else $error("outputs do not match stages");

   // A sampled pin fall is taken exactly two cycles later, once the flops have run
   a_pin_latency: assert property (
      $fell(clk_pin) && $past(rst_n_q) |-> ##2 fall)
      else $error("pin edge not seen in time");
endmodule

// [testbench/word_receiver.sv]
// Far-side model: pausable register clock and a stalling word receiver
`timescale 1ns/1ps
module word_receiver (
   // Clock
   input wire logic mclk,
   // Controls from the bench
   input wire logic en,
   input wire logic stall,
   // Register clock pin
   output logic clk_pin,
   // Word stream
   input wire logic word_valid,
   input wire logic [3:0] word_data,
   output logic word_ready
);
   logic [1:0] cnt_q = 2'h0;
   shift4_pkg::stage_word_t got[$];
   initial clk_pin = 1'b1;
   initial word_ready = 1'b0;
   // Pausing parks the clock high, so no stray falling edge is made
   always @(posedge mclk) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == 2'h3 && (en || !clk_pin)) begin
         clk_pin <= ~clk_pin;
      end
   end
   // Random pace; a word is taken at the edge that sees ready high
   always @(posedge mclk) begin
      if (word_valid && word_ready) begin
         got.push_back(word_data);
      end
      word_ready <= !stall && ($urandom % 2 == 0);
   end
endmodule

// [testbench/test_four_bit_shift_register.sv]
// Self-checking bench for the four-stage shift register
`timescale 1ns/1ps
module test_four_bit_shift_register;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic clear_n_pin = 1'b1;
   logic load_pin = 1'b0;
   logic shift_pin = 1'b0;
   logic ser_pin = 1'b0;
   logic [3:0] par_pin = 4'h0;
   logic en = 1'b0;
   logic stall = 1'b0;
   logic seen;
   logic clk_pin;
   logic word_ready;
   logic ser_out;
   logic ser_out_n;
   logic word_valid;
   logic word_room;
   shift4_pkg::stage_word_t par_out;
   shift4_pkg::stage_word_t word_data;
   int err_total = 0;
   int num_checks = 0;
   int st = 0;
   int exp_q[$];

   always #10 mclk = ~mclk;

   shift4_reg i_dut (.mclk(mclk), .nrst(nrst), .clk_pin(clk_pin), .clear_n_pin(clear_n_pin),
      .load_pin(load_pin), .shift_pin(shift_pin), .ser_pin(ser_pin), .par_pin(par_pin),
      .par_out(par_out), .ser_out(ser_out), .ser_out_n(ser_out_n), .word_valid(word_valid),
      .word_data(word_data), .word_ready(word_ready), .word_room(word_room));

   word_receiver i_rx (.mclk(mclk), .en(en), .stall(stall), .clk_pin(clk_pin),
      .word_valid(word_valid), .word_data(word_data), .word_ready(word_ready));

   task automatic check(logic [3:0] got, logic [3:0] want);
      num_checks++;
      if (got !== want) begin
         err_total++;
         $display("ERROR %0t ns: seen %h expected %h", $time, got, want);
      end
   endtask

   task automatic conclude();
      if (err_total == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   task automatic check_stages();
      check(par_out, 4'(st));
      check({3'h0, ser_out}, {3'h0, st[3]});
      check({3'h0, ser_out_n}, {3'h0, ~st[3]});
      while (i_rx.got.size() > 0 && exp_q.size() > 0) begin
         check(i_rx.got.pop_front(), 4'(exp_q.pop_front()));
      end
   endtask

   // Checks land five cycles after a fall, past the worst-case answer time
   // Controls change just after a check, far from the next fall
   task automatic run(int n);
      en = 1'b1;
      repeat (n) begin
         {load_pin, shift_pin} = 2'($urandom);
         ser_pin = 1'($urandom);
         par_pin = 4'($urandom);
         @(posedge clk_pin);
         tick(1);
         check_stages();
      end
   endtask

   // Reference stages: bit0 is stage one, so a left shift moves bits upward
   always @(negedge clk_pin) begin
      if (nrst && clear_n_pin) begin
         if (shift_pin) begin
            st = ((st << 1) | ser_pin) & 15;
         end else if (load_pin) begin
            st = par_pin;
         end
         exp_q.push_back(st);
      end
   end

   initial begin
      void'($urandom(32'h24c39424));
      tick(2);
      check(par_out, 4'h0);
      check({ser_out_n, word_valid, word_room, 1'b0}, 4'h8);
      tick(1);
      nrst = 1'b1;
      tick(6);
      run(60);
      // Stalled receiver over five hold edges fills the skid until it refuses
      {load_pin, shift_pin} = 2'h0;
      stall = 1'b1;
      repeat (5) @(posedge clk_pin);
      tick(1);
      check({3'h0, word_room}, 4'h0);
      stall = 1'b0;
      en = 1'b0;
      tick(40);
      check({3'h0, word_valid}, 4'h0);
      check_stages();
      exp_q.delete();
      i_rx.got.delete();
      // Clear with the clock parked, then let edges arrive during clear
      clear_n_pin = 1'b0;
      tick(5);
      st = 0;
      check(par_out, 4'h0);
      check({3'h0, ser_out_n}, 4'h1);
      {load_pin, shift_pin} = 2'h2;
      par_pin = 4'hf;
      seen = 1'b0;
      en = 1'b1;
      repeat (12) begin
         tick(1);
         if (par_out !== 4'h0) begin
            seen = 1'b1;
         end
      end
      en = 1'b0;
      check({3'h0, seen}, 4'h1);
      tick(12);
      check(par_out, 4'h0);
      clear_n_pin = 1'b1;
      tick(12);
      exp_q.delete();
      i_rx.got.delete();
      run(40);
      conclude();
   end

   // Watchdog well beyond the expected run of about a thousand cycles
   initial begin
      #200000;
      err_total++;
      conclude();
   end
endmodule
